// >>> loader_pkg.sv
// Shared constants and types of the serial loader packet engine.
// Assumes byte-wide links and a single 100 MHz clock domain.
package loader_pkg;

    // ****************************************
    // Protocol bytes and command codes
    // ****************************************
    localparam logic [7:0] ACK_BYTE = 8'hCC;
    localparam logic [7:0] NAK_BYTE = 8'h33;
    localparam logic [7:0] CMD_PING = 8'h20;
    localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
    localparam logic [7:0] CMD_RUN = 8'h22;
    localparam logic [7:0] CMD_QUERY_LAST_RESULT = 8'h23;
    localparam logic [7:0] CMD_SEND_DATA = 8'h24;
    localparam logic [7:0] CMD_RESET = 8'h25;

    // ****************************************
    // Packet lengths and field positions
    // ****************************************
    localparam logic [7:0] LEN_MIN = 8'h03;
    localparam logic [7:0] LEN_PING = 8'h03;
    localparam logic [7:0] LEN_DOWNLOAD = 8'h0B;
    localparam logic [7:0] LEN_RUN = 8'h07;
    localparam logic [7:0] LEN_RESET = 8'h03;
    localparam logic [7:0] LEN_REPLY = 8'h03;
    localparam logic [7:0] DATA_MAX = 8'h08;
    localparam int PAYLOAD_MAX = 9;
    localparam int POS_ADDR = 1;
    localparam int POS_SIZE = 5;
    localparam logic [1:0] REPLY_LAST = 2'h2;

    // ****************************************
    // Status codes and reset values
    // ****************************************
    localparam logic [7:0] STAT_SUCCESS = 8'h40;
    localparam logic [7:0] STAT_UNKNOWN_CMD = 8'h41;
    localparam logic [7:0] STAT_INVALID_CMD = 8'h42;
    localparam logic [7:0] STAT_FLASH_FAIL = 8'h44;
    localparam logic [7:0] STATUS_RESET = 8'h40;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

    // ****************************************
    // Buffering
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 32;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SUM = 4'h1,
        ST_BODY = 4'h3,
        ST_CHECK = 4'h2,
        ST_FLASH = 4'h6,
        ST_ACK = 4'h7,
        ST_POST = 4'h5,
        ST_REPLY = 4'h4,
        ST_RESP = 4'hC,
        ST_HALT = 4'hD
    } state_t;

    typedef enum logic [1:0] {
        LOCK_NONE = 2'h0,
        LOCK_A = 2'h1,
        LOCK_B = 2'h2
    } lock_t;

endpackage

// >>> byte_stream_if.sv
// Valid/ready stream carrier between the engine and its receive FIFO.
// Assumes both ends share one clock.
interface byte_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// >>> byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; storage is flip-flops addressed by pointers.
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Filling side
    byte_stream_if.snk wr,
    // Draining side
    byte_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign wr.ready = (count != (AW+1)'(DEPTH));
    assign rd.valid = (count != '0);
    assign rd.data = mem[rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    // Storage write
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wp] <= wr.data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop)
            begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// >>> serial_loader_packet_engine.sv
// Packet engine of a serial loader: receives checksummed packets, acknowledges them,
// runs loader commands and sends status replies.
// Assumes byte-level serial ports outside and an abstract flash controller.
//
// Summary of operation
// - First packet byte is total length including length and checksum bytes.
// - Second byte is the eight-bit sum of the payload bytes only.
// - Answer each packet with 0xCC if intact, 0x33 if not.
// - Acknowledge depends only on packet integrity, never on command validity.
// - Reply may lead with zeros, then length, checksum, payload without gaps.
// - Awaiting host response, skip zero bytes, take first non-zero byte.
// - First payload byte is a command code, parameters follow.
// - Ping of three bytes sets last status to success.
// - Status query answers with a one-byte status reply packet.
// - Download setup is eleven bytes: address then count, most significant first.
// - Download setup erases the whole region before acknowledging.
// - Data command programs at current address, then advances it.
// - Programming stops when received data reaches the setup byte count.
// - A negatively acknowledged data command leaves the address unchanged.
// - Run command of seven bytes acknowledges before transferring execution.
// - Reset command of three bytes acknowledges before software reset.
// - After traffic starts on one port, ignore the other port.
module serial_loader_packet_engine (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Port A byte link
    input wire logic rx_valid_a,
    input wire logic [7:0] rx_byte_a,
    output logic rx_ready_a,
    output logic tx_valid_a,
    input wire logic tx_ready_a,
    // Port B byte link
    input wire logic rx_valid_b,
    input wire logic [7:0] rx_byte_b,
    output logic rx_ready_b,
    output logic tx_valid_b,
    input wire logic tx_ready_b,
    // Shared transmit byte
    output logic [7:0] tx_byte,
    // Flash controller request
    output logic fl_req,
    output logic fl_erase,
    output logic [31:0] fl_addr,
    output logic [31:0] fl_len,
    output logic [63:0] fl_data,
    input wire logic fl_done,
    input wire logic fl_error,
    // Control transfer
    output logic run_req,
    output logic [31:0] run_addr,
    output logic sw_reset_req,
    // Status
    output logic [7:0] last_status,
    output loader_pkg::lock_t port_lock
);
    import loader_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    byte_stream_if #(.WIDTH(BYTE_W)) rx_in();
    byte_stream_if #(.WIDTH(BYTE_W)) rx_out();

    state_t state;
    logic [7:0] pkt_len;
    logic [7:0] bytes_left;
    logic [7:0] sum_want;
    logic [7:0] sum_acc;
    logic [7:0] pay_idx;
    logic [7:0] payload [PAYLOAD_MAX];
    logic [7:0] ack_code;
    logic exec_ok;
    logic [31:0] cur_addr;
    logic [31:0] rem_count;
    logic dl_active;
    logic [1:0] tx_idx;
    logic sel_a;
    logic sel_b;
    logic pop;
    logic [7:0] in_byte;
    logic tx_fire;
    logic pkt_ok;
    logic [7:0] cmd;
    logic [7:0] data_n;
    logic [7:0] take_n;
    logic dl_ok;
    logic data_ok;
    logic flash_go;
    logic soft_clr;
    logic [63:0] data_word;

    // Gathers four payload bytes, most significant first
    function automatic logic [31:0] be32(input int base);
        return {payload[base], payload[base+1], payload[base+2], payload[base+3]};
    endfunction

    // ****************************************
    // Port selection and receive FIFO
    // ****************************************
    // Until locked, port A wins a tie; afterwards the other port is drained and dropped
    assign sel_a = (port_lock == LOCK_A) || ((port_lock == LOCK_NONE) && rx_valid_a);
    assign sel_b = (port_lock == LOCK_B) || ((port_lock == LOCK_NONE) && !rx_valid_a);
    assign rx_in.valid = sel_a ? rx_valid_a : rx_valid_b;
    assign rx_in.data = sel_a ? rx_byte_a : rx_byte_b;
    assign rx_ready_a = sel_a ? rx_in.ready : (port_lock == LOCK_B);
    assign rx_ready_b = sel_b ? rx_in.ready : (port_lock == LOCK_A);

    byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(ref_clk),
        .rstn(rstn),
        .wr(rx_in.snk),
        .rd(rx_out.src)
    );

    // Bytes are drained only while a packet or a response is awaited
    assign pop = rx_out.valid && ((state == ST_IDLE) || (state == ST_SUM) ||
                 (state == ST_BODY) || (state == ST_RESP));
    assign rx_out.ready = pop;
    assign in_byte = rx_out.data;
    assign tx_fire = (tx_valid_a && tx_ready_a) || (tx_valid_b && tx_ready_b);

    // ****************************************
    // Command decode
    // ****************************************
    assign pkt_ok = (pkt_len >= LEN_MIN) && (sum_acc == sum_want);
    assign cmd = payload[0];
    assign data_n = pkt_len - LEN_MIN;
    assign take_n = (rem_count < 32'(data_n)) ? rem_count[7:0] : data_n;
    assign dl_ok = (pkt_len == LEN_DOWNLOAD) && (be32(POS_SIZE) != '0);
    assign data_ok = dl_active && (data_n != '0) && (data_n <= DATA_MAX) && (rem_count != '0);
    assign flash_go = pkt_ok && (((cmd == CMD_DOWNLOAD) && dl_ok) || ((cmd == CMD_SEND_DATA) && data_ok));
    assign soft_clr = (state == ST_POST) && exec_ok && (cmd == CMD_RESET);

    // Program word: data bytes in arrival order, unused lanes zero
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_lane
            assign data_word[i*8 +: 8] = (8'(i) < take_n) ? payload[i+1] : 8'h00;
        end
    endgenerate

    // ****************************************
    // Sequencer
    // ****************************************
    // Packet receive, execute, acknowledge and reply sequence
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    if (pop && (in_byte != 8'h00))
                    begin
                        state <= (in_byte == 8'h01) ? ST_CHECK : ST_SUM;
                    end
                ST_SUM:
                    if (pop)
                    begin
                        state <= (pkt_len == 8'h02) ? ST_CHECK : ST_BODY;
                    end
                ST_BODY:
                    if (pop && (bytes_left == 8'h01))
                    begin
                        state <= ST_CHECK;
                    end
                ST_CHECK:
                    state <= flash_go ? ST_FLASH : ST_ACK;
                ST_FLASH:
                    if (fl_done)
                    begin
                        state <= ST_ACK;
                    end
                ST_ACK:
                    if (tx_fire)
                    begin
                        state <= ST_POST;
                    end
                ST_POST:
                    if (!exec_ok)
                    begin
                        state <= ST_IDLE;
                    end
                    else if (cmd == CMD_QUERY_LAST_RESULT)
                    begin
                        state <= ST_REPLY;
                    end
                    else if (cmd == CMD_RUN)
                    begin
                        state <= ST_HALT;
                    end
                    else
                    begin
                        state <= ST_IDLE;
                    end
                ST_REPLY:
                    if (tx_fire && (tx_idx == REPLY_LAST))
                    begin
                        state <= ST_RESP;
                    end
                ST_RESP:
                    if (pop && (in_byte != 8'h00))
                    begin
                        state <= ST_IDLE;
                    end
                ST_HALT:
                    state <= ST_HALT;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Port lock on the first accepted byte
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            port_lock <= LOCK_NONE;
        end
        else if (soft_clr)
        begin
            port_lock <= LOCK_NONE;
        end
        else if ((port_lock == LOCK_NONE) && rx_in.valid && rx_in.ready)
        begin
            port_lock <= sel_a ? LOCK_A : LOCK_B;
        end
    end

    // ****************************************
    // Packet capture
    // ****************************************
    // Length, checksum and payload collection
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pkt_len <= 8'h00;
            bytes_left <= 8'h00;
            sum_want <= 8'h00;
            sum_acc <= 8'h00;
            pay_idx <= 8'h00;
            for (int i = 0; i < PAYLOAD_MAX; i++)
            begin
                payload[i] <= 8'h00;
            end
        end
        else if (pop)
        begin
            if ((state == ST_IDLE) && (in_byte != 8'h00))
            begin
                pkt_len <= in_byte;
                bytes_left <= in_byte - 8'h02;
                payload[0] <= 8'h00;
            end
            else if (state == ST_SUM)
            begin
                sum_want <= in_byte;
                sum_acc <= 8'h00;
                pay_idx <= 8'h00;
            end
            else if (state == ST_BODY)
            begin
                sum_acc <= sum_acc + in_byte;
                bytes_left <= bytes_left - 8'h01;
                pay_idx <= pay_idx + 8'h01;
                if (pay_idx < 8'(PAYLOAD_MAX))
                begin
                    payload[pay_idx[3:0]] <= in_byte;
                end
            end
        end
    end

    // ****************************************
    // Loader state and status
    // ****************************************
    // Acknowledge code and permission to act on the command
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_code <= NAK_BYTE;
            exec_ok <= 1'b0;
        end
        else if (state == ST_CHECK)
        begin
            ack_code <= pkt_ok ? ACK_BYTE : NAK_BYTE;
            exec_ok <= pkt_ok && !((cmd == CMD_RUN) && (pkt_len != LEN_RUN)) &&
                       !((cmd == CMD_RESET) && (pkt_len != LEN_RESET));
        end
    end

    // Last-command status
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            last_status <= STATUS_RESET;
        end
        else if (soft_clr)
        begin
            last_status <= STATUS_RESET;
        end
        else if ((state == ST_CHECK) && pkt_ok)
        begin
            case (cmd)
                CMD_PING:
                    last_status <= (pkt_len == LEN_PING) ? STAT_SUCCESS : STAT_INVALID_CMD;
                CMD_QUERY_LAST_RESULT:
                    last_status <= last_status;
                CMD_DOWNLOAD:
                    last_status <= dl_ok ? last_status : STAT_INVALID_CMD;
                CMD_SEND_DATA:
                    last_status <= data_ok ? last_status : STAT_INVALID_CMD;
                CMD_RUN:
                    last_status <= (pkt_len == LEN_RUN) ? STAT_SUCCESS : STAT_INVALID_CMD;
                CMD_RESET:
                    last_status <= (pkt_len == LEN_RESET) ? STAT_SUCCESS : STAT_INVALID_CMD;
                default:
                    last_status <= STAT_UNKNOWN_CMD;
            endcase
        end
        else if ((state == ST_FLASH) && fl_done)
        begin
            last_status <= fl_error ? STAT_FLASH_FAIL : STAT_SUCCESS;
        end
    end

    // Programming address, remaining count and download window
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cur_addr <= ADDR_RESET;
            rem_count <= '0;
            dl_active <= 1'b0;
        end
        else if (soft_clr)
        begin
            cur_addr <= ADDR_RESET;
            rem_count <= '0;
            dl_active <= 1'b0;
        end
        else if ((state == ST_CHECK) && pkt_ok && (cmd == CMD_DOWNLOAD))
        begin
            cur_addr <= dl_ok ? be32(POS_ADDR) : cur_addr;
            rem_count <= dl_ok ? be32(POS_SIZE) : rem_count;
            dl_active <= 1'b0;
        end
        else if ((state == ST_FLASH) && fl_done)
        begin
            if (fl_erase)
            begin
                dl_active <= !fl_error;
            end
            else if (!fl_error)
            begin
                cur_addr <= cur_addr + fl_len;
                rem_count <= rem_count - fl_len;
            end
        end
    end

    // ****************************************
    // Flash request
    // ****************************************
    // Request held from decode until the controller reports done
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fl_req <= 1'b0;
            fl_erase <= 1'b0;
            fl_addr <= '0;
            fl_len <= '0;
            fl_data <= '0;
        end
        else if ((state == ST_CHECK) && flash_go)
        begin
            fl_req <= 1'b1;
            if (cmd == CMD_DOWNLOAD)
            begin
                fl_erase <= 1'b1;
                fl_addr <= be32(POS_ADDR);
                fl_len <= be32(POS_SIZE);
                fl_data <= '0;
            end
            else
            begin
                fl_erase <= 1'b0;
                fl_addr <= cur_addr;
                fl_len <= 32'(take_n);
                fl_data <= data_word;
            end
        end
        else if ((state == ST_FLASH) && fl_done)
        begin
            fl_req <= 1'b0;
        end
    end

    // ****************************************
    // Transmit
    // ****************************************
    // Acknowledge byte, then optional three-byte status reply sent back to back
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_byte <= 8'h00;
            tx_valid_a <= 1'b0;
            tx_valid_b <= 1'b0;
            tx_idx <= 2'h0;
        end
        else if (tx_fire)
        begin
            if ((state == ST_REPLY) && (tx_idx != REPLY_LAST))
            begin
                tx_byte <= last_status;
                tx_idx <= tx_idx + 2'h1;
            end
            else
            begin
                tx_valid_a <= 1'b0;
                tx_valid_b <= 1'b0;
            end
        end
        else if (((state == ST_CHECK) && !flash_go) || ((state == ST_FLASH) && fl_done))
        begin
            tx_byte <= (state == ST_CHECK) ? (pkt_ok ? ACK_BYTE : NAK_BYTE) : ack_code;
            tx_valid_a <= (port_lock == LOCK_A);
            tx_valid_b <= (port_lock == LOCK_B);
        end
        else if ((state == ST_POST) && exec_ok && (cmd == CMD_QUERY_LAST_RESULT))
        begin
            tx_byte <= LEN_REPLY;
            tx_idx <= 2'h0;
            tx_valid_a <= (port_lock == LOCK_A);
            tx_valid_b <= (port_lock == LOCK_B);
        end
    end

    // ****************************************
    // Control transfer
    // ****************************************
    // Run and reset pulses issued only after the acknowledge has gone out
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_req <= 1'b0;
            run_addr <= '0;
            sw_reset_req <= 1'b0;
        end
        else
        begin
            run_req <= (state == ST_POST) && exec_ok && (cmd == CMD_RUN);
            sw_reset_req <= soft_clr;
            if ((state == ST_POST) && exec_ok && (cmd == CMD_RUN))
            begin
                run_addr <= be32(POS_ADDR);
            end
        end
    end
endmodule

// >>> loader_sva.sv
// Port checker of the serial loader packet engine.
// Assumes it is bound onto the engine's top module.
module loader_sva
import loader_pkg::*;
(
    // Watched ports
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic tx_valid_a,
    input wire logic tx_ready_a,
    input wire logic tx_valid_b,
    input wire logic [7:0] tx_byte,
    input wire logic fl_req,
    input wire logic fl_erase,
    input wire logic [31:0] fl_addr,
    input wire logic [31:0] fl_len,
    input wire logic fl_done,
    input wire logic run_req,
    input wire loader_pkg::lock_t port_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Assertions
    // ****************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_tx_hold: assert property (tx_valid_a && !tx_ready_a |=> tx_valid_a && $stable(tx_byte))
        else $error("tx byte lost");
    a_fl_hold: assert property (fl_req && !fl_done |=> fl_req && $stable(fl_addr) && $stable(fl_len))
        else $error("flash request moved");
    a_fl_drop: assert property (fl_req && fl_done |=> !fl_req)
        else $error("flash request kept");
    a_ack_flash: assert property (fl_req |-> !tx_valid_a)
        else $error("ack before flash done");
    a_run_pulse: assert property (run_req |=> !run_req)
        else $error("run pulse long");
    a_prog_len: assert property (fl_req && !fl_erase |-> fl_len inside {[1:8]})
        else $error("program length");
    a_lock_keep: assert property (port_lock == LOCK_A |=> port_lock != LOCK_B)
        else $error("lock jumped");
    a_other_quiet: assert property (port_lock == LOCK_A |-> !tx_valid_b)
        else $error("other port sent");
    c_erase: cover property (fl_req && fl_erase);
    c_prog: cover property (fl_req && !fl_erase);
    c_run: cover property (run_req);
endmodule
bind serial_loader_packet_engine loader_sva u_sva (.*);

// >>> flash_model.sv
// Flash controller stand-in: answers each request after a few cycles.
// Assumes requests are held until done.
module flash_model (
    // Clock, reset and request
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic fl_req,
    input wire logic fl_fail,
    output logic fl_done,
    output logic fl_error
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    // Count request cycles, then pulse done
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= 2'h0;
            fl_done <= 1'b0;
        end
        else
        begin
            cnt <= (fl_req && !fl_done) ? cnt + 2'h1 : 2'h0;
            fl_done <= fl_req && !fl_done && cnt == 2'h2;
        end
    end
    // Bench-chosen failure qualifies every done pulse
    assign fl_error = fl_fail;
endmodule

// >>> serial_loader_packet_engine_tb.sv
// Self-checking bench of the loader engine, host on port A.
// Assumes the flash model answers every request.
module serial_loader_packet_engine_tb
import loader_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rstn = 1'b0, rx_valid_a = 1'b0, rx_valid_b = 1'b0, tx_ready_a = 1'b0, tx_ready_b = 1'b1;
    logic [7:0] rx_byte_a = 8'h00, rx_byte_b = 8'h55, tx_byte, last_status, d[$];
    logic rx_ready_a, rx_ready_b, tx_valid_a, tx_valid_b, fl_req, fl_erase, fl_done, fl_error, run_req, sw_reset_req;
    logic [31:0] fl_addr, fl_len, run_addr;
    logic [63:0] fl_data;
    logic fl_fail = 1'b0;
    lock_t port_lock;
    int failures = 0, num_checks = 0;
    // ****************
    // Harness
    // ****************
    always #5 ref_clk = ~ref_clk;
    serial_loader_packet_engine u_dut (.*);
    flash_model u_flash (.*);
    // Compare and count
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Offer raw bytes on port A
    task put(input logic [7:0] q[$]);
        @(posedge ref_clk);
        foreach (q[i])
        begin
            rx_valid_a <= 1'b1;
            rx_byte_a <= q[i];
            @(posedge ref_clk);
            while (!rx_ready_a) @(posedge ref_clk);
        end
        rx_valid_a <= 1'b0;
    endtask
    // Frame a payload; bias spoils the sum
    task send(input logic [7:0] p[$], input logic [7:0] bias);
        logic [7:0] s;
        s = bias;
        foreach (p[i]) s += p[i];
        put({8'(p.size() + 2), s, p});
    endtask
    // Wait for a signal, bounded
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (s !== 1'b1 && n < 3000)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (s !== 1'b1)
        begin
            failures++;
            $display("unexpected wait expected 1 seen %b", s);
        end
    endtask
    // Take one byte after a stall
    task get(input logic [7:0] e, input string nm);
        wait_hi(tx_valid_a);
        @(posedge ref_clk);
        tx_ready_a <= 1'b1;
        chk(nm, e, tx_byte);
        @(posedge ref_clk);
        tx_ready_a <= 1'b0;
    endtask
    // Status query, reply bytes, host acknowledge
    task ask(input logic [7:0] st);
        send('{CMD_QUERY_LAST_RESULT}, 8'h00);
        get(ACK_BYTE, "ack");
        get(LEN_REPLY, "len");
        get(st, "sum");
        get(st, "status");
        put('{8'h00, ACK_BYTE});
    endtask
    // Reset values, unknown command, status reply, ping, other port
    task t_query;
        chk("reset status", STATUS_RESET, last_status);
        chk("reset lock", LOCK_NONE, port_lock);
        send('{8'h30}, 8'h00);
        get(ACK_BYTE, "ack");
        ask(STAT_UNKNOWN_CMD);
        rx_valid_b <= 1'b1;
        send('{CMD_PING}, 8'h00);
        get(ACK_BYTE, "ping");
        chk("status", STAT_SUCCESS, last_status);
        chk("b drop", 1'b1, rx_ready_b);
        rx_valid_b <= 1'b0;
    endtask
    // Setup, data, corrupt data, tail, spent count
    task t_load;
        send('{CMD_DOWNLOAD, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C}, 8'h00);
        wait_hi(fl_req);
        chk("erase flag", 1'b1, fl_erase);
        chk("erase range", {fl_addr, fl_len}, 64'h0000_1000_0000_000C);
        get(ACK_BYTE, "ack");
        ask(STAT_SUCCESS);
        d = '{CMD_SEND_DATA, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
        send(d, 8'h00);
        wait_hi(fl_req);
        chk("prog", {fl_addr, fl_data[31:0]}, 64'h0000_1000_0403_0201);
        get(ACK_BYTE, "ack");
        send(d, 8'h01);
        get(NAK_BYTE, "nak");
        fl_fail <= 1'b1;
        send(d, 8'h00);
        get(ACK_BYTE, "ack");
        chk("flash fail", STAT_FLASH_FAIL, last_status);
        fl_fail <= 1'b0;
        send(d, 8'h00);
        wait_hi(fl_req);
        chk("tail", {fl_addr, fl_len}, 64'h0000_1008_0000_0004);
        get(ACK_BYTE, "ack");
        send(d, 8'h00);
        get(ACK_BYTE, "ack");
        chk("spent", STAT_INVALID_CMD, last_status);
    endtask
    // Reset, then run
    task t_end;
        send('{CMD_RESET}, 8'h00);
        get(ACK_BYTE, "ack");
        wait_hi(sw_reset_req);
        chk("reset", 1'b1, sw_reset_req);
        chk("lock free", LOCK_NONE, port_lock);
        send('{CMD_RUN, 8'h00, 8'h00, 8'h20, 8'h00}, 8'h00);
        get(ACK_BYTE, "ack");
        wait_hi(run_req);
        chk("run", 32'h0000_2000, run_addr);
    endtask
    // Counts and verdict
    task print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        t_query();
        t_load();
        t_end();
        print_verdict();
    end
    // Watchdog
    initial
    begin
        #400000;
        failures++;
        print_verdict();
    end
endmodule
